/* logic/bldcs_div_if.sv */
// Request and answer of the duty divider.
// Assumes one master (the sequencer) and one slave (the divider).
`timescale 1ns/10ps
`default_nettype none
interface bldcs_div_if #(parameter int CW = 12, parameter int QW = 9);
    logic start;
    logic [CW-1:0] num;
    logic [CW-1:0] den;
    logic busy;
    logic done;
    logic [QW-1:0] quo;
    modport master(output start, num, den, input busy, done, quo);
    modport slave(input start, num, den, output busy, done, quo);
endinterface
`default_nettype wire

/* logic/bldcs_duty_div.sv */
// Restoring divider giving high time over period as a duty code.
// Assumes the master starts it only while it is not busy.
`timescale 1ns/10ps
`default_nettype none
module bldcs_duty_div #(
    parameter int CW = 12,
    parameter int QW = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    bldcs_div_if.slave dv
);
    localparam int STW = $clog2(QW + 1);
    logic [CW:0] rem_r;
    logic [CW-1:0] den_r;
    logic [QW-1:0] quo_r;
    logic [STW-1:0] step_r;
    logic busy_r;
    logic done_r;
    wire [CW:0] shifted;
    wire ge;
    wire [CW:0] diff;

    // One quotient bit per step
    assign shifted = {rem_r[CW-1:0], 1'b0};
    assign ge = (shifted >= {1'b0, den_r});
    assign diff = shifted - {1'b0, den_r};
    assign dv.busy = busy_r;
    assign dv.done = done_r;
    assign dv.quo = quo_r;

    // Load, iterate, and pulse done with the result
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rem_r <= '0;
            den_r <= '0;
            quo_r <= '0;
            step_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ce) begin
            done_r <= 1'b0;
            if (dv.start && !busy_r) begin
                if (dv.num >= dv.den) begin
                    quo_r <= '1; // Full duty saturates
                    done_r <= 1'b1;
                end else begin
                    rem_r <= {1'b0, dv.num};
                    den_r <= dv.den;
                    step_r <= STW'(QW);
                    busy_r <= 1'b1;
                end
            end else if (busy_r) begin
                rem_r <= ge ? diff : shifted;
                quo_r <= {quo_r[QW-2:0], ge};
                step_r <= step_r - STW'(1);
                if (step_r == STW'(1)) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* logic/bldcs_lowtmr.sv */
// Low-time timeout counter for one control input.
// Assumes the input is synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module bldcs_lowtmr #(
    parameter int LIMIT = 100000,
    parameter int CW = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic level,
    output logic expired
);
    logic [CW-1:0] cnt_r;

    // Expires once low for more than the limit
    assign expired = (cnt_r > CW'(LIMIT));

    // Counts low cycles, cleared whenever the input is high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (ce) begin
            if (level) begin
                cnt_r <= '0;
            end else if (!expired) begin
                cnt_r <= cnt_r + CW'(1);
            end
        end
    end
endmodule
`default_nettype wire

/* logic/bldcs_pkg.sv */
// Types shared by the backlight control sequencer.
// Assumes nothing of its surroundings.
`default_nettype none
package bldcs_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_OFF, ST_CHECK, ST_RUN, ST_PAUSE, ST_NOSTART, ST_LATCH
    } bldcs_state_t;
endpackage
`default_nettype wire

/* logic/bldcs_regs.svh */
// Named constants of the backlight control sequencer.
// Assumes the clock is the internal switching reference at 40 MHz.
`ifndef BLDCS_REGS_SVH
`define BLDCS_REGS_SVH
// Clock rate in hertz
`define BLDCS_CLK_HZ 40.0e6
// Enable low time to shutdown, ms
`define BLDCS_T_EN_SD_MS 2.5
// Dimming input low time to shutdown, ms
`define BLDCS_T_PWM_SD_MS 20.0
// Reduced switch current limit window after start, ms
`define BLDCS_T_ILIM_WIN_MS 5.0
// Lowest dimming frequency, kHz
`define BLDCS_PWM_FMIN_KHZ 10.0
// Settling cycles of the channel check
`define BLDCS_CHECK_CYC 4'h8
`endif

/* logic/bldcs_top.sv */
// Control and sequencing logic of a two-channel LED backlight driver.
// Assumes all inputs are synchronous comparator or pin levels and that
// the boost loop, sinks and current limit themselves are analog.
//
// How it works
// - Enable low beyond 2.5 ms shuts down
// - Dimming low beyond 20 ms shuts down
// - Start needs supply, enable and dimming
// - Grounded sink channels are disabled at start
// - All sinks grounded: never start switching
// - Switching only after the channel check
// - Sink reference equals full scale times duty
// - Steady high dimming gives full scale
// - Undervoltage stops driver, restarts after recovery
// - Switch node overvoltage each cycle latches off
// - Active sink pin overvoltage triggers protection
// - Regulate on lowest active sink level
// - Reduced current limit for 5 ms
// - Slope compensation above half boost duty
`timescale 1ns/10ps
`default_nettype none
`include "bldcs_regs.svh"
module bldcs_top #(
    parameter int N = 2,
    parameter int FBW = 8,
    parameter int RW = 9,
    parameter int CW = 12,
    parameter int TW = 20,
    parameter int EN_SD_CYC =
        int'($ceil(`BLDCS_T_EN_SD_MS * 1.0e-3 * `BLDCS_CLK_HZ)),
    parameter int PWM_SD_CYC =
        int'($ceil(`BLDCS_T_PWM_SD_MS * 1.0e-3 * `BLDCS_CLK_HZ)),
    parameter int ILIM_WIN_CYC =
        int'($ceil(`BLDCS_T_ILIM_WIN_MS * 1.0e-3 * `BLDCS_CLK_HZ)),
    parameter int SELW = (N > 1) ? $clog2(N) : 1
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    input wire logic EN,
    input wire logic PWM,
    input wire logic UV_OK,
    input wire logic THERM_HOT,
    input wire logic NODE_CYCLE,
    input wire logic GATE_ON,
    input wire logic NODE_OV,
    input wire logic [N-1:0] SINK_GND,
    input wire logic [N-1:0] SINK_OV,
    input wire logic [N*FBW-1:0] SINK_FB_LVL,
    output logic BOOST_EN,
    output logic [N-1:0] SINK_EN,
    output logic [RW-1:0] CURRENT_REF,
    output logic [SELW-1:0] FB_SELECT,
    output logic [FBW-1:0] FB_MIN_LVL,
    output logic STARTUP_CURRENT_LIMIT,
    output logic SLOPE_COMP_EN,
    output logic FAULT_LATCHED,
    output logic SHUTDOWN
);
    // Longest dimming period at the lowest frequency
    localparam int PER_MAX_CYC =
        int'($floor(`BLDCS_CLK_HZ / (`BLDCS_PWM_FMIN_KHZ * 1.0e3)));
    localparam logic [CW-1:0] PER_MAX = CW'(PER_MAX_CYC);

    bldcs_pkg::bldcs_state_t state_r, state_nxt;
    logic en_sd, pwm_sd, sd_req, start_ok, hold_off, prot_trip;
    logic pwm_seen_r, fault_r;
    logic [3:0] chk_cnt_r;
    logic [N-1:0] act_r;
    logic [TW-1:0] ilim_cnt_r;
    logic pwm_d_r, per_valid_r;
    logic [CW-1:0] per_cnt_r, hi_cnt_r;
    logic [RW-1:0] ref_r;
    logic [7:0] on_cnt_r, tot_cnt_r;
    logic slope_r;
    logic [SELW-1:0] sel_r, sel_c;
    logic [FBW-1:0] min_r, min_c;
    wire pwm_rise, steady, chk_done, run_entry;

    bldcs_div_if #(.CW(CW), .QW(RW)) div_bus ();

    // Low-time timeouts on the two control inputs
    bldcs_lowtmr #(.LIMIT(EN_SD_CYC), .CW(TW)) u_en_tmr (
        .clk(REF_CLK), .rst_n(RESETN), .ce(CLK_EN),
        .level(EN), .expired(en_sd)
    );
    bldcs_lowtmr #(.LIMIT(PWM_SD_CYC), .CW(TW)) u_pwm_tmr (
        .clk(REF_CLK), .rst_n(RESETN), .ce(CLK_EN),
        .level(PWM), .expired(pwm_sd)
    );
    bldcs_duty_div #(.CW(CW), .QW(RW)) u_div (
        .clk(REF_CLK), .rst_n(RESETN), .ce(CLK_EN), .dv(div_bus.slave)
    );

    // Sequencer conditions
    assign sd_req = en_sd | pwm_sd;
    assign start_ok = UV_OK & EN & pwm_seen_r & ~sd_req;
    assign hold_off = ~UV_OK | THERM_HOT;
    assign prot_trip = (NODE_CYCLE & NODE_OV)
        | (|(SINK_OV & act_r));
    assign chk_done = (chk_cnt_r == `BLDCS_CHECK_CYC);
    assign run_entry = (state_r == bldcs_pkg::ST_CHECK) && chk_done
        && !hold_off && !sd_req && (|(~SINK_GND));

    // Next state of the sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bldcs_pkg::ST_OFF: begin
                if (start_ok) begin
                    state_nxt = bldcs_pkg::ST_CHECK;
                end
            end
            bldcs_pkg::ST_CHECK: begin
                if (hold_off) begin
                    state_nxt = bldcs_pkg::ST_PAUSE;
                end else if (chk_done && !(|(~SINK_GND))) begin
                    state_nxt = bldcs_pkg::ST_NOSTART;
                end else if (chk_done) begin
                    state_nxt = bldcs_pkg::ST_RUN;
                end
            end
            bldcs_pkg::ST_RUN: begin
                if (prot_trip) begin
                    state_nxt = bldcs_pkg::ST_LATCH;
                end else if (hold_off) begin
                    state_nxt = bldcs_pkg::ST_PAUSE;
                end
            end
            bldcs_pkg::ST_PAUSE: begin
                if (!hold_off) begin
                    state_nxt = bldcs_pkg::ST_CHECK;
                end
            end
            bldcs_pkg::ST_NOSTART: state_nxt = state_r;
            bldcs_pkg::ST_LATCH: state_nxt = state_r;
            default: state_nxt = bldcs_pkg::ST_OFF;
        endcase
        if (sd_req) begin
            state_nxt = bldcs_pkg::ST_OFF;
        end
    end

    // State register, dimming presence and fault latch
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            state_r <= bldcs_pkg::ST_OFF;
            pwm_seen_r <= 1'b0;
            fault_r <= 1'b0;
        end else if (CLK_EN) begin
            state_r <= state_nxt;
            pwm_seen_r <= PWM | (pwm_seen_r & ~pwm_sd);
            if (state_nxt == bldcs_pkg::ST_LATCH) begin
                fault_r <= 1'b1;
            end else if (state_r == bldcs_pkg::ST_OFF && start_ok) begin
                fault_r <= 1'b0;
            end
        end
    end

    // Channel check: settle, then keep channels not tied low
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            chk_cnt_r <= 4'h0;
            act_r <= '0;
        end else if (CLK_EN) begin
            if (state_r != bldcs_pkg::ST_CHECK) begin
                chk_cnt_r <= 4'h0;
            end else if (!chk_done) begin
                chk_cnt_r <= chk_cnt_r + 4'h1;
            end
            if (state_r == bldcs_pkg::ST_CHECK && chk_done) begin
                act_r <= ~SINK_GND;
            end else if (state_r == bldcs_pkg::ST_OFF) begin
                act_r <= '0;
            end
        end
    end

    // Reduced current limit window from the first switching cycle
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            ilim_cnt_r <= '0;
        end else if (CLK_EN) begin
            if (run_entry && state_r != bldcs_pkg::ST_RUN) begin
                ilim_cnt_r <= TW'(ILIM_WIN_CYC);
            end else if (state_r != bldcs_pkg::ST_RUN) begin
                ilim_cnt_r <= '0;
            end else if (ilim_cnt_r != '0) begin
                ilim_cnt_r <= ilim_cnt_r - TW'(1);
            end
        end
    end

    // Dimming edge, steady level and divider request
    assign pwm_rise = PWM & ~pwm_d_r;
    assign steady = (per_cnt_r == PER_MAX);
    assign div_bus.start = pwm_rise & per_valid_r & ~steady
        & ~div_bus.busy;
    assign div_bus.num = hi_cnt_r;
    assign div_bus.den = per_cnt_r + CW'(1);

    // Period and high-time counters between rising edges
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            pwm_d_r <= 1'b0;
            per_valid_r <= 1'b0;
            per_cnt_r <= '0;
            hi_cnt_r <= '0;
        end else if (CLK_EN) begin
            pwm_d_r <= PWM;
            if (pwm_rise) begin
                per_cnt_r <= '0;
                hi_cnt_r <= CW'(1);
                per_valid_r <= 1'b1;
            end else if (!steady) begin
                per_cnt_r <= per_cnt_r + CW'(1);
                hi_cnt_r <= hi_cnt_r + CW'(PWM);
            end else begin
                per_valid_r <= 1'b0;
            end
        end
    end

    // Current reference: measured duty, or the steady level
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            ref_r <= '0;
        end else if (CLK_EN) begin
            if (steady) begin
                ref_r <= PWM ? '1 : '0;
            end else if (div_bus.done) begin
                ref_r <= div_bus.quo;
            end
        end
    end

    // Boost duty per switching cycle
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            on_cnt_r <= 8'h00;
            tot_cnt_r <= 8'h00;
            slope_r <= 1'b0;
        end else if (CLK_EN) begin
            if (NODE_CYCLE) begin
                slope_r <= ({on_cnt_r, 1'b0} > {1'b0, tot_cnt_r});
                on_cnt_r <= {7'h00, GATE_ON};
                tot_cnt_r <= 8'h01;
            end else if (tot_cnt_r != 8'hFF) begin
                on_cnt_r <= on_cnt_r + {7'h00, GATE_ON};
                tot_cnt_r <= tot_cnt_r + 8'h01;
            end
        end
    end

    // Lowest level among active sinks
    always_comb begin
        min_c = '1;
        sel_c = '0;
        for (int i = 0; i < N; i++) begin
            if (act_r[i] && SINK_FB_LVL[i*FBW +: FBW] < min_c) begin
                min_c = SINK_FB_LVL[i*FBW +: FBW];
                sel_c = SELW'(i);
            end
        end
    end

    // Registered feedback choice
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            min_r <= '0;
            sel_r <= '0;
        end else if (CLK_EN) begin
            min_r <= min_c;
            sel_r <= sel_c;
        end
    end

    // Outputs
    assign BOOST_EN = (state_r == bldcs_pkg::ST_RUN);
    assign SINK_EN = BOOST_EN ? act_r : '0;
    assign CURRENT_REF = ref_r;
    assign FB_SELECT = sel_r;
    assign FB_MIN_LVL = min_r;
    assign STARTUP_CURRENT_LIMIT = BOOST_EN & (ilim_cnt_r != '0);
    assign SLOPE_COMP_EN = BOOST_EN & slope_r;
    assign FAULT_LATCHED = fault_r;
    assign SHUTDOWN = (state_r == bldcs_pkg::ST_OFF);

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN || !CLK_EN);

    sequence s_check_pass;
        (state_r == bldcs_pkg::ST_CHECK) ##1 (state_r == bldcs_pkg::ST_RUN);
    endsequence
    sequence s_trip;
        BOOST_EN && prot_trip && !sd_req;
    endsequence

    a_start_qualified: assert property (
        $rose(state_r == bldcs_pkg::ST_CHECK) && $past(SHUTDOWN)
        |-> $past(UV_OK && EN && pwm_seen_r))
        else $error("start without qualification");
    a_check_first: assert property ($rose(BOOST_EN) |->
        $past(state_r == bldcs_pkg::ST_CHECK))
        else $error("switching before channel check");
    a_all_grounded: assert property (
        state_r == bldcs_pkg::ST_CHECK && chk_done && SINK_GND == '1
        && !sd_req |=> !BOOST_EN [*2])
        else $error("started with every sink grounded");
    a_ovp_latch: assert property (s_trip |=>
        FAULT_LATCHED && !BOOST_EN)
        else $error("overvoltage did not latch off");
    a_fault_holds: assert property (FAULT_LATCHED
        && !(SHUTDOWN && start_ok) |=> FAULT_LATCHED)
        else $error("latched fault cleared without a new start");
    a_uv_off: assert property (BOOST_EN && !UV_OK && !prot_trip
        && !sd_req |=> !BOOST_EN && state_r == bldcs_pkg::ST_PAUSE)
        else $error("driver kept on in undervoltage");
    a_timeout_shut: assert property (sd_req |=> SHUTDOWN)
        else $error("timeout did not shut down");
    a_en_clear: assert property (EN |=> !en_sd)
        else $error("enable timeout not cleared by high");
    a_ilim_window: assert property (s_check_pass |->
        STARTUP_CURRENT_LIMIT [*8])
        else $error("reduced limit window missing");
    a_full_scale: assert property (PWM && steady |=>
        CURRENT_REF == '1)
        else $error("steady high not at full scale");
    a_sink_mask: assert property (BOOST_EN |->
        (SINK_EN & ~act_r) == '0 && SINK_EN != '0)
        else $error("grounded channel enabled");
    a_sink_latch: assert property (s_check_pass |->
        SINK_EN == ~$past(SINK_GND))
        else $error("sink enables differ from the channel check");
endmodule
`default_nettype wire

/* test/bldcs_host_model.sv */
// Host side model: drives the enable and dimming pins of the sequencer.
// Assumes a free running clock; both pins change on its falling edge.
`timescale 1ns/10ps
`default_nettype none
module bldcs_host_model (
    input wire logic clk,
    input wire logic en_req,
    input wire logic [15:0] period,
    input wire logic [15:0] high,
    input wire logic level,
    output logic en_pin,
    output logic pwm_pin
);
    logic [15:0] cnt_r = 16'h0000;
    logic wrap;
    // Period counter of the dimming waveform, zero period means static
    assign wrap = (period == 16'h0000) || (cnt_r >= period - 16'h0001);
    always @(negedge clk) begin
        cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
    end
    // Both pins are always driven, never left to the pull-down
    assign en_pin = en_req;
    assign pwm_pin = (period == 16'h0000) ? level
        : (cnt_r < high);
endmodule
`default_nettype wire

/* test/bldcs_top_tb.sv */
// Self-checking bench of the backlight control sequencer.
// Assumes short timeouts (50, 600, 30 cycles) set through parameters.
`timescale 1ns/10ps
`default_nettype none
module bldcs_top_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en_req = 1'b0;
    logic lvl = 1'b0;
    logic [15:0] period = 16'h0000;
    logic [15:0] high = 16'h0000;
    logic uv_ok = 1'b0;
    logic hot = 1'b0;
    logic node_cycle = 1'b0;
    logic gate_on = 1'b0;
    logic node_ov = 1'b0;
    logic [1:0] sink_gnd = 2'h0;
    logic [1:0] sink_ov = 2'h0;
    logic clk_en = 1'b1;
    logic [15:0] fb_lvl = 16'h3040;
    logic en_pin, pwm_pin, boost_en, ilim, slope, fault, shutdown;
    logic [1:0] sink_en;
    logic [8:0] cur_ref;
    logic [0:0] fb_sel;
    logic [7:0] fb_min;
    int n_fail = 0;
    int checks_done = 0;
    int n;

    // Clock at 40 MHz
    initial begin
        forever #12.5 clk = ~clk;
    end

    bldcs_host_model host (.clk(clk), .en_req(en_req), .period(period),
        .high(high), .level(lvl), .en_pin(en_pin), .pwm_pin(pwm_pin));

    bldcs_top #(.EN_SD_CYC(50), .PWM_SD_CYC(600), .ILIM_WIN_CYC(30)) uut (
        .REF_CLK(clk), .RESETN(rst_n), .CLK_EN(clk_en), .EN(en_pin),
        .PWM(pwm_pin), .UV_OK(uv_ok), .THERM_HOT(hot),
        .NODE_CYCLE(node_cycle), .GATE_ON(gate_on), .NODE_OV(node_ov),
        .SINK_GND(sink_gnd), .SINK_OV(sink_ov),
        .SINK_FB_LVL(fb_lvl), .BOOST_EN(boost_en),
        .SINK_EN(sink_en), .CURRENT_REF(cur_ref), .FB_SELECT(fb_sel),
        .FB_MIN_LVL(fb_min), .STARTUP_CURRENT_LIMIT(ilim),
        .SLOPE_COMP_EN(slope), .FAULT_LATCHED(fault),
        .SHUTDOWN(shutdown));

    // Compare and count
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic pick(input int which);
        return (which == 0) ? boost_en : shutdown;
    endfunction

    // Bounded wait for boost (0) or shutdown (1) to reach a level
    task automatic wait_sig(input int which, input logic val,
                            input int lim, output int cnt);
        cnt = 0;
        while (pick(which) !== val) begin
            @(negedge clk);
            cnt++;
            if (cnt > lim) begin
                n_fail++;
                $display("[FAIL] wait %0d expected %b seen timeout", which, val);
                end_of_test();
            end
        end
    endtask

    // Start from off with given grounded sinks
    task automatic power_up(input logic [1:0] gnd);
        sink_gnd = gnd;
        uv_ok = 1'b1;
        en_req = 1'b1;
        period = 16'h0000;
        lvl = 1'b1;
        wait_sig(1, 1'b0, 20, n);
        wait_sig(0, 1'b1, 20, n);
        chk("check cycles", 16'(n), 16'h0009);
        chk("sink enables", 16'(sink_en), {14'h0000, ~gnd});
        chk("start limit", 16'(ilim), 16'h0001);
        chk("fault cleared", 16'(fault), 16'h0000);
    endtask

    // Shutdown through a long enable low
    task automatic shut_by_en();
        en_req = 1'b0;
        wait_sig(1, 1'b1, 80, n);
        chk("enable timeout", 16'(n >= 51 && n <= 54), 16'h0001);
        chk("boost off", 16'(boost_en), 16'h0000);
    endtask

    task automatic t_start();
        en_req = 1'b1;
        lvl = 1'b1;
        repeat (20) @(negedge clk);
        chk("no start low supply", 16'(shutdown), 16'h0001);
        power_up(2'h2);
        repeat (2) @(negedge clk);
        chk("fb select", 16'(fb_sel), 16'h0000);
        chk("fb level", 16'(fb_min), 16'h0040);
        repeat (35) @(negedge clk);
        chk("normal limit", 16'(ilim), 16'h0000);
        repeat (4100) @(negedge clk);
        chk("steady high ref", 16'(cur_ref), 16'h01FF);
        $display("test start done");
    endtask

    task automatic t_duty();
        logic [15:0] tab [3][3];
        tab = '{'{16'h0190, 16'h0064, 16'h0080},
                '{16'h0190, 16'h012C, 16'h0180},
                '{16'h07D0, 16'h05DC, 16'h0180}};
        for (int i = 0; i < 3; i++) begin
            period = tab[i][0];
            high = tab[i][1];
            repeat (3 * tab[i][0] + 50) @(negedge clk);
            chk("duty ref", 16'(cur_ref), tab[i][2]);
        end
        $display("test duty done");
    endtask

    task automatic t_slope();
        logic [3:0] on [3] = '{4'h6, 4'h5, 4'h4};
        for (int k = 0; k < 3; k++) begin
            repeat (4) begin
                for (int i = 0; i < 10; i++) begin
                    node_cycle = (i == 0);
                    gate_on = (i < on[k]);
                    @(negedge clk);
                end
            end
            chk("slope comp", 16'(slope), 16'(k == 0));
        end
        node_cycle = 1'b0;
        gate_on = 1'b0;
        $display("test slope done");
    endtask

    task automatic t_fault();
        for (int k = 0; k < 2; k++) begin
            sink_ov = 2'h2;
            repeat (3) @(negedge clk);
            chk("inactive sink ov", 16'(fault), 16'h0000);
            node_ov = (k == 0);
            node_cycle = (k == 0);
            sink_ov = (k == 0) ? 2'h0 : 2'h1;
            @(negedge clk);
            {node_ov, node_cycle, sink_ov} = 4'h0;
            @(negedge clk);
            chk("fault latched", 16'(fault), 16'h0001);
            chk("boost stopped", 16'(boost_en), 16'h0000);
            repeat (20) @(negedge clk);
            chk("fault holds", 16'(fault), 16'h0001);
            shut_by_en();
            power_up(2'h2);
        end
        $display("test fault done");
    endtask

    task automatic t_pause();
        for (int k = 0; k < 2; k++) begin
            uv_ok = (k != 0);
            hot = (k != 0);
            repeat (3) @(negedge clk);
            chk("paused", 16'(boost_en), 16'h0000);
            chk("not off", 16'(shutdown), 16'h0000);
            uv_ok = 1'b1;
            hot = 1'b0;
            wait_sig(0, 1'b1, 20, n);
            chk("resume", 16'(n >= 9 && n <= 11), 16'h0001);
        end
        $display("test pause done");
    endtask

    task automatic t_pwm_low();
        lvl = 1'b0;
        repeat (550) @(negedge clk);
        lvl = 1'b1;
        @(negedge clk);
        lvl = 1'b0;
        repeat (550) @(negedge clk);
        chk("short dim low", 16'(shutdown), 16'h0000);
        wait_sig(1, 1'b1, 120, n);
        chk("dim timeout", 16'(n >= 51 && n <= 54), 16'h0001);
        power_up(2'h2);
        $display("test dim low done");
    endtask

    task automatic t_en_low();
        en_req = 1'b0;
        repeat (45) @(negedge clk);
        en_req = 1'b1;
        @(negedge clk);
        en_req = 1'b0;
        repeat (45) @(negedge clk);
        en_req = 1'b1;
        @(negedge clk);
        chk("short enable low", 16'(boost_en), 16'h0001);
        clk_en = 1'b0;
        en_req = 1'b0;
        repeat (60) @(negedge clk);
        clk_en = 1'b1;
        en_req = 1'b1;
        @(negedge clk);
        chk("frozen enable low", 16'(boost_en), 16'h0001);
        shut_by_en();
        power_up(2'h0);
        repeat (2) @(negedge clk);
        chk("fb select both", 16'(fb_sel), 16'h0001);
        chk("fb level both", 16'(fb_min), 16'h0030);
        fb_lvl = 16'h5020;
        repeat (2) @(negedge clk);
        chk("fb select swap", 16'(fb_sel), 16'h0000);
        chk("fb level swap", 16'(fb_min), 16'h0020);
        shut_by_en();
        sink_gnd = 2'h3;
        en_req = 1'b1;
        wait_sig(1, 1'b0, 20, n);
        repeat (40) @(negedge clk);
        chk("all grounded", 16'(boost_en), 16'h0000);
        chk("no start held", 16'(shutdown), 16'h0000);
        $display("test enable low done");
    endtask

    // Main sequence
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_start();
        t_duty();
        t_slope();
        t_fault();
        t_pause();
        t_pwm_low();
        t_en_low();
        end_of_test();
    end
endmodule
`default_nettype wire
